// ---- rcsbp_cs_decode.sv ----
// One ROM chip-select decoder with a registered active-low output.
`timescale 1ns/10ps
module rcsbp_cs_decode
  import rcsbp_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Control and access
  input  wire rcsbp_ctrl_t   ctrl,
  input  wire rcsbp_access_t acc,
  // Select
  output logic               rom_chip_select_n
);

  // =====================================================================
  // Address compare
  // =====================================================================
  // Compare width grows as capacity shrinks; unused compare bits are ignored.
  wire logic [1:0] cap_code = {ctrl.capacity_sel_hi, ctrl.capacity_sel_lo};
  wire logic [3:0] top_bits = acc.addr[ADDR_TOP_BIT -: 4];
  wire logic [3:0] cmp_mask = (cap_code == CAP_256M) ? 4'h8 :
                              (cap_code == CAP_128M) ? 4'hC :
                              (cap_code == CAP_64M)  ? 4'hE :
                                                       4'hF;
  wire logic       addr_hit = ((top_bits ^ ctrl.compare) & cmp_mask) == 4'h0;
  wire logic       area_hit = (ctrl.area_select == AREA_SEL_ZERO) ? acc.area0 : acc.area2;
  wire logic       next_sel = acc.active && area_hit && addr_hit;

  // Output is registered so the pin never glitches on address decode.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rom_chip_select_n <= 1'h1;
    end else begin
      rom_chip_select_n <= ~next_sel;
    end
  end

endmodule

// ---- rcsbp_monitor.sv ----
// Port checks for the ROM select and pull-up block.
`timescale 1ns/10ps
module rcsbp_monitor
  import rcsbp_pkg::*;
#(parameter int unsigned SELECTS = NUM_SELECTS)
(
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // Inputs of the block
  input wire logic                      addr_pullup_en,
  input wire logic                      data_pullup_en,
  input wire rcsbp_ctrl_t [SELECTS-1:0] rom_cs_ctrl_reg,
  input wire logic [SELECTS-1:0][1:0]   port_c_ctrl_reg,
  input wire rcsbp_access_t             access,
  input wire logic                      access_done,
  input wire logic                      data_bus_busy,
  input wire logic                      bus_grant,
  // Outputs of the block
  input wire logic [SELECTS-1:0]        rom_chip_select_n,
  input wire logic [SELECTS-1:0]        port_c_pin_is_cs,
  input wire logic                      area0_pin_is_cs,
  input wire logic                      area0_select_n,
  input wire logic                      area2_select_n,
  input wire logic                      addr_pullup_on,
  input wire logic                      data_pullup_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A grant taken with the enable set, then held four more cycles.
  sequence s_grant;
    !bus_grant ##1 (bus_grant && addr_pullup_en);
  endsequence
  sequence s_held;
    s_grant ##1 bus_grant[*4];
  endsequence
  a_pull_four: assert property (s_held |-> addr_pullup_on && $past(addr_pullup_on, 3))
    else $error("address pull-up too short");
  a_pull_ends: assert property (s_held |=> !addr_pullup_on)
    else $error("address pull-up too long");
  a_pull_grant: assert property (addr_pullup_on |-> $past(bus_grant))
    else $error("address pull-up without grant");
  a_data_idle: assert property (data_pullup_en && !data_bus_busy |=> data_pullup_on)
    else $error("data pull-up missing");
  a_data_busy: assert property (data_bus_busy |=> !data_pullup_on)
    else $error("data pull-up while busy");
  a_cs_active: assert property (!(&rom_chip_select_n) |-> $past(access.active))
    else $error("select without access");
  // A select may only go low on a pin that has been switched over.
  a_cs_pin: assert property (&(rom_chip_select_n | $past(port_c_pin_is_cs)))
    else $error("select on unswitched pin");
  // A switched area-0 pin follows select 0 exactly.
  a_area0_route: assert property ($past(area0_pin_is_cs) |-> area0_select_n == rom_chip_select_n[0])
    else $error("area-0 pin not following select 0");
  a_area2_sel: assert property (!$past(rst) |-> area2_select_n == !$past(access.active && access.area2))
    else $error("area-2 select wrong");
  a_pin_switch: assert property ((|(port_c_pin_is_cs & ~$past(port_c_pin_is_cs)))
    |-> $past(access_done && access.area0))
    else $error("pin switched without area-0 access");
  a_area0_switch: assert property ($rose(area0_pin_is_cs) |-> $past(access_done && access.area0
    && !rom_cs_ctrl_reg[0].area_select && port_c_ctrl_reg[0] == PORT_MODE_ALT))
    else $error("area-0 pin switched wrongly");
endmodule
bind rcsbp_top rcsbp_monitor #(.SELECTS(SELECTS)) u_mon (.core_clk(core_clk), .rst(rst),
  .addr_pullup_en(addr_pullup_en), .data_pullup_en(data_pullup_en),
  .rom_cs_ctrl_reg(rom_cs_ctrl_reg), .port_c_ctrl_reg(port_c_ctrl_reg), .access(access),
  .access_done(access_done), .data_bus_busy(data_bus_busy), .bus_grant(bus_grant),
  .rom_chip_select_n(rom_chip_select_n), .port_c_pin_is_cs(port_c_pin_is_cs),
  .area0_pin_is_cs(area0_pin_is_cs), .area0_select_n(area0_select_n),
  .area2_select_n(area2_select_n), .addr_pullup_on(addr_pullup_on),
  .data_pullup_on(data_pullup_on));

// ---- rcsbp_pkg.sv ----
// Package with constants and carrier types for the ROM chip-select and bus pull-up block.
//
// Notes on behaviour
// - Address pull-up four clocks after grant.
// - Data pull-up while data bus idle.
// - Eight ROM selects, each own control.
// - Capacity 32 to 256 Mbit sets compare width.
// - 256 Mbit compares address bit 25.
// - 128 Mbit compares address bits 25:24.
// - 64 Mbit compares address bits 25:23.
// - 32 Mbit compares address bits 25:22.
// - Assert only during selected area access.
// - Select 0 area 0 also takes area-0 pin.
// - Pin changeover after next area-0 access.
package rcsbp_pkg;

  // =====================================================================
  // Widths and counts
  // =====================================================================
  localparam int unsigned NUM_SELECTS    = 8;
  localparam int unsigned ADDR_WIDTH     = 26;
  localparam int unsigned DATA_WIDTH     = 32;
  localparam int unsigned PULLUP_CLOCKS  = 4;
  localparam int unsigned PULL_CNT_WIDTH = 3;

  // =====================================================================
  // Field positions and encodings
  // =====================================================================
  localparam int unsigned ADDR_TOP_BIT   = 25;
  localparam logic [1:0]  CAP_32M        = 2'h0;
  localparam logic [1:0]  CAP_64M        = 2'h1;
  localparam logic [1:0]  CAP_128M       = 2'h2;
  localparam logic [1:0]  CAP_256M       = 2'h3;
  localparam logic [1:0]  PORT_MODE_ALT  = 2'h0;
  localparam logic [1:0]  PORT_MODE_RST  = 2'h2;
  localparam logic        AREA_SEL_ZERO  = 1'h0;

  // =====================================================================
  // Carrier types
  // =====================================================================
  // One chip-select control register.
  typedef struct packed {
    logic       area_select;
    logic       capacity_sel_hi;
    logic       capacity_sel_lo;
    logic [3:0] compare;
  } rcsbp_ctrl_t;

  // One external bus access as seen by the controller.
  typedef struct packed {
    logic                  active;
    logic                  area0;
    logic                  area2;
    logic [ADDR_WIDTH-1:0] addr;
  } rcsbp_access_t;

  // Pull-up engine state.
  typedef enum logic [2:0] {
    RCSBP_OWN     = 3'h1,
    RCSBP_PULLING = 3'h2,
    RCSBP_HELD    = 3'h4
  } rcsbp_pull_state_t;

endpackage

// ---- rcsbp_rom_model.sv ----
// External ROM devices that note each selected cycle.
`timescale 1ns/10ps
module rcsbp_rom_model
  import rcsbp_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Selects and seen flags
  input  wire logic [NUM_SELECTS-1:0] rom_chip_select_n,
  output logic [NUM_SELECTS-1:0]      rom_seen
);
  // Flags stick until reset, so a device that was never selected shows it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rom_seen <= '0;
    end else begin
      rom_seen <= rom_seen | ~rom_chip_select_n;
    end
  end
endmodule

// ---- rcsbp_top.sv ----
// Top level of the ROM chip-select and bus pull-up block.
`timescale 1ns/10ps
module rcsbp_top
  import rcsbp_pkg::*;
#(
  parameter int unsigned SELECTS = NUM_SELECTS
)
(
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // Bus control bits
  input  wire logic                            addr_pullup_en,
  input  wire logic                            data_pullup_en,
  // Chip-select control registers and port C modes
  input  wire rcsbp_ctrl_t [SELECTS-1:0]       rom_cs_ctrl_reg,
  input  wire logic [SELECTS-1:0][1:0]         port_c_ctrl_reg,
  // Bus state from the controller
  input  wire rcsbp_access_t                   access,
  input  wire logic                            access_done,
  input  wire logic                            data_bus_busy,
  input  wire logic                            bus_grant,
  // Select outputs
  output logic [SELECTS-1:0]                   rom_chip_select_n,
  output logic [SELECTS-1:0]                   port_c_pin_is_cs,
  output logic                                 area0_pin_is_cs,
  output logic                                 area0_select_n,
  output logic                                 area2_select_n,
  // Pull-up enables
  output logic                                 addr_pullup_on,
  output logic                                 data_pullup_on
);

  // =====================================================================
  // Elaboration checks
  // =====================================================================
  if (SELECTS < 1 || SELECTS > NUM_SELECTS) begin : g_bad_selects
    $error("SELECTS must be between one and eight.");
  end

  // =====================================================================
  // Chip-select decoders
  // =====================================================================
  wire logic [SELECTS-1:0] cs_raw_n;

  // One decoder per select, each governed by its own control register.
  for (genvar i = 0; i < SELECTS; i++) begin : g_cs
    rcsbp_cs_decode u_dec (
      .core_clk          (core_clk),
      .rst               (rst),
      .ctrl              (rom_cs_ctrl_reg[i]),
      .acc               (access),
      .rom_chip_select_n (cs_raw_n[i])
    );
  end

  // =====================================================================
  // Pin changeover
  // =====================================================================
  // Port writes land late, so the mode takes effect only after an area-0 access.
  wire logic [SELECTS-1:0] mode_alt;
  for (genvar i = 0; i < SELECTS; i++) begin : g_mode
    assign mode_alt[i] = port_c_ctrl_reg[i] == PORT_MODE_ALT;
  end
  wire logic area0_done  = access_done && access.area0;
  wire logic next_a0_cs  = mode_alt[0] && (rom_cs_ctrl_reg[0].area_select == AREA_SEL_ZERO);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_c_pin_is_cs <= '0;
      area0_pin_is_cs  <= 1'h0;
    end else if (area0_done) begin
      port_c_pin_is_cs <= mode_alt;
      area0_pin_is_cs  <= next_a0_cs;
    end
  end

  // Pin state as it stood when the current decode was taken. The access that
  // performs the changeover must still run on the old pin function, so the
  // select outputs are gated by this delayed copy, which lines up with the
  // registered decode in each select decoder.
  logic [SELECTS-1:0] pin_was_cs;
  logic               a0_pin_was_cs;
  logic               a0_plain_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_was_cs <= '0;
    end else begin
      pin_was_cs <= port_c_pin_is_cs;
    end
  end

  // Selects drive low only on pins that had switched over before the access.
  assign rom_chip_select_n = cs_raw_n | ~pin_was_cs;

  // Plain area selects are registered like the ROM selects to keep timing equal.
  wire logic next_a0_n = ~(access.active && access.area0);
  wire logic next_a2_n = ~(access.active && access.area2);

  // The plain area-0 select and the pin function are kept apart, so that the
  // switched pin shows the select-0 decode with the same one-cycle delay.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a0_plain_n     <= 1'h1;
      a0_pin_was_cs  <= 1'h0;
      area2_select_n <= 1'h1;
    end else begin
      a0_plain_n     <= next_a0_n;
      a0_pin_was_cs  <= area0_pin_is_cs;
      area2_select_n <= next_a2_n;
    end
  end

  // Once switched, the area-0 pin carries select 0 instead of the plain select.
  assign area0_select_n = a0_pin_was_cs ? cs_raw_n[0] : a0_plain_n;

  // =====================================================================
  // Address pull-up
  // =====================================================================
  rcsbp_pull_state_t                 pull_state;
  rcsbp_pull_state_t                 next_pull_state;
  logic [PULL_CNT_WIDTH-1:0]         pull_cnt;
  logic [PULL_CNT_WIDTH-1:0]         next_pull_cnt;
  localparam logic [PULL_CNT_WIDTH-1:0] PULL_LAST = PULL_CNT_WIDTH'(PULLUP_CLOCKS - 1);

  // The pull lasts four clocks from grant; afterwards the master drives the pins.
  always_comb begin
    next_pull_state = pull_state;
    next_pull_cnt   = pull_cnt;
    case (pull_state)
      RCSBP_OWN: begin
        if (bus_grant && addr_pullup_en) begin
          next_pull_state = RCSBP_PULLING;
          next_pull_cnt   = '0;
        end else if (bus_grant) begin
          next_pull_state = RCSBP_HELD;
        end
      end
      RCSBP_PULLING: begin
        if (!bus_grant) begin
          next_pull_state = RCSBP_OWN;
        end else if (pull_cnt == PULL_LAST) begin
          next_pull_state = RCSBP_HELD;
        end else begin
          next_pull_cnt = pull_cnt + 1'h1;
        end
      end
      RCSBP_HELD: begin
        if (!bus_grant) begin
          next_pull_state = RCSBP_OWN;
        end
      end
      default: begin
        next_pull_state = RCSBP_OWN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pull_state <= RCSBP_OWN;
      pull_cnt   <= '0;
    end else begin
      pull_state <= next_pull_state;
      pull_cnt   <= next_pull_cnt;
    end
  end

  assign addr_pullup_on = pull_state == RCSBP_PULLING;

  // =====================================================================
  // Data pull-up
  // =====================================================================
  // Pulled up whenever no read or write uses the data bus.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_pullup_on <= 1'h0;
    end else begin
      data_pullup_on <= data_pullup_en && !data_bus_busy;
    end
  end

endmodule

// ---- rcsbp_top_tb.sv ----
// Self-checking bench for the ROM select and pull-up block.
`timescale 1ns/10ps
module rcsbp_top_tb
  import rcsbp_pkg::*;
;
  logic              core_clk = 1'b0, rst = 1'b1, apu_en = 1'b0, dpu_en = 1'b0;
  logic              done = 1'b0, busy = 1'b0, grant = 1'b0;
  rcsbp_ctrl_t [7:0] ctrl = '0;
  logic [7:0][1:0]   mode = {8{PORT_MODE_RST}};
  rcsbp_access_t     acc = '0;
  logic [7:0]        cs_n, pin_cs, seen;
  logic              a0_cs, apu, dpu, a0_n, a2_n;
  int                fails = 0, check_count = 0;
  always #25 core_clk = ~core_clk;
  rcsbp_top #(.SELECTS(8)) DUT (.core_clk(core_clk), .rst(rst), .addr_pullup_en(apu_en),
    .data_pullup_en(dpu_en), .rom_cs_ctrl_reg(ctrl), .port_c_ctrl_reg(mode), .access(acc),
    .access_done(done), .data_bus_busy(busy), .bus_grant(grant), .rom_chip_select_n(cs_n),
    .port_c_pin_is_cs(pin_cs), .area0_pin_is_cs(a0_cs), .area0_select_n(a0_n), .area2_select_n(a2_n),
    .addr_pullup_on(apu), .data_pullup_on(dpu));
  rcsbp_rom_model u_rom (.core_clk(core_clk), .rst(rst), .rom_chip_select_n(cs_n), .rom_seen(seen));
  task automatic cmp_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_vec(what, {7'h00, exp}, {7'h00, got});
  endtask
  // Expected selects; a capacity code widens the ignored low compare bits.
  function automatic logic [7:0] exp_cs(input logic [25:0] a, input logic a2);
    logic [7:0] r;
    r = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      if (ctrl[i].area_select == a2 && ((a[25:22] ^ ctrl[i].compare)
          & (4'hF << {ctrl[i].capacity_sel_hi, ctrl[i].capacity_sel_lo})) == 4'h0)
        r[i] = 1'b0;
    end
    return r;
  endfunction
  // One access cycle, entered and left at a falling edge; the access stays on.
  task automatic bus_access(input logic [25:0] a, input logic a2, input logic d);
    acc = '{1'b1, !a2, a2, a};
    done = d;
    @(negedge core_clk);
  endtask
  // Drops the access for one cycle, so no signal is set twice at one instant.
  task automatic bus_idle();
    acc = '0;
    done = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_switch();
    bus_access(26'h0000000, 1'b0, 1'b1);
    cmp_vec("selects unswitched", 8'hFF, cs_n);
    bus_idle();
    mode = '0;
    repeat (3) @(negedge core_clk);
    bus_access(26'h0000000, 1'b1, 1'b1);
    cmp_bit("area-2 select", 1'b0, a2_n);
    bus_idle();
    cmp_vec("pins before area-0", 8'h00, pin_cs);
    bus_access(26'h0000000, 1'b0, 1'b1);
    cmp_vec("switching access", 8'hFF, cs_n);
    cmp_bit("area-0 plain", 1'b0, a0_n);
    bus_idle();
    cmp_vec("pins switched", 8'hFF, pin_cs);
    cmp_bit("area-0 pin", 1'b1, a0_cs);
    cmp_vec("devices untouched", 8'h00, seen);
    $display("test switch ended");
  endtask
  task automatic t_decode();
    logic [25:0] a;
    logic [7:0]  e;
    for (int c = 3; c >= 0; c--) begin
      for (int i = 0; i < 8; i++)
        ctrl[i] = '{i[0], c[1], c[0], 4'(i * 3)};
      for (int t = 0; t < 32; t++) begin
        a = {t[3:0], {22{t[0]}}};
        e = exp_cs(a, t[4]);
        bus_access(a, t[4], 1'b0);
        cmp_vec("selects", e, cs_n);
        cmp_bit("area-0 select", e[0], a0_n);
        cmp_bit("area-2 select", !t[4], a2_n);
        bus_idle();
        cmp_vec("selects idle", 8'hFF, cs_n);
      end
    end
    cmp_vec("devices seen", 8'hFF, seen);
    $display("test decode ended");
  endtask
  task automatic t_pullup();
    apu_en = 1'b1;
    dpu_en = 1'b1;
    grant = 1'b1;
    for (int k = 1; k <= 6; k++) begin
      @(negedge core_clk);
      cmp_bit("address pull-up", k < 5, apu);
    end
    cmp_bit("data pull-up idle", 1'b1, dpu);
    busy = 1'b1;
    grant = 1'b0;
    apu_en = 1'b0;
    @(negedge core_clk);
    grant = 1'b1;
    @(negedge core_clk);
    cmp_bit("data pull-up busy", 1'b0, dpu);
    cmp_bit("address pull-up off", 1'b0, apu);
    grant = 1'b0;
    apu_en = 1'b1;
    @(negedge core_clk);
    grant = 1'b1;
    @(negedge core_clk);
    cmp_bit("address pull-up regrant", 1'b1, apu);
    grant = 1'b0;
    @(negedge core_clk);
    cmp_bit("address pull-up cut", 1'b0, apu);
    $display("test pull-up ended");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    t_switch();
    t_decode();
    t_pullup();
    conclude();
  end
endmodule
